// *** bench/task_switch_control_tb.sv ***
/*
 task_switch_control_tb: directed scenarios for the task switch block.
 assumes: tsc_mem_model answers memory ops; inputs change on the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module task_switch_control_tb;
  logic clk = 1'b0, srst = 1'b1, xreq = 1'b0, dtask = 1'b0, trap = 1'b0, crwr = 1'b0;
  logic fwr = 1'b0, insw = 1'b0, hret = 1'b0, pfe = 1'b0, fpx = 1'b0, ce = 1'b1;
  logic [2:0] kind = 3'h0;
  logic [3:0] typ = 4'h0, mdly = 4'h1;
  logic [1:0] crsel = 2'h0;
  logic [15:0] sel = 16'h0;
  logic [31:0] daddr = 32'h0, base = 32'h0, lim = 32'h0, nflg = 32'h0;
  logic [31:0] crd = 32'h0, fd = 32'h0, pfl = 32'h0;
  logic mack, mreq, flush, excv, plain, real_a, busy;
  logic [1:0] mop;
  logic [7:0] vec;
  logic [15:0] o_sel;
  logic [31:0] mdat, maddr, o_base, o_lim, flg, mcw, pfla, pdb;
  int err_total = 0, compares = 0, n_exc = 0, n_flush = 0, n_plain = 0, n_busy = 0;
  logic [7:0] last_vec = 8'h00; // vector of the latest exception pulse
  task_switch_control DUT (
    .I_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_XFER_REQ(xreq), .I_XFER_KIND(kind),
    .I_DESC_TASK(dtask), .I_NEW_SEL(sel), .I_NEW_DESC_ADDR(daddr), .I_NEW_TYPE(typ),
    .I_NEW_BASE(base), .I_NEW_LIMIT(lim), .I_NEW_TRAP(trap), .I_NEW_FLAGS(nflg),
    .I_MEM_ACK(mack), .I_CR_WR(crwr), .I_CR_SEL(crsel), .I_CR_DATA(crd),
    .I_FLAG_WR(fwr), .I_FLAG_DATA(fd), .I_INT_NOSWITCH(insw), .I_HANDLER_RET(hret),
    .I_PF_EVENT(pfe), .I_PF_LINEAR(pfl), .I_FP_EXEC(fpx), .O_MEM_REQ(mreq),
    .O_MEM_OP(mop), .O_MEM_ADDR(maddr), .O_MEM_DATA(mdat), .O_TASK_SEL(o_sel),
    .O_TASK_BASE(o_base), .O_TASK_LIMIT(o_lim), .O_FLAGS(flg), .O_MCW(mcw),
    .O_PFLA(pfla), .O_PDB(pdb), .O_TLB_FLUSH(flush), .O_EXC_VALID(excv),
    .O_EXC_VECTOR(vec), .O_PLAIN_RETURN(plain), .O_REAL_ADDR(real_a),
    .O_SWITCH_BUSY(busy));
  tsc_mem_model mem (.i_clk(clk), .i_req(mreq), .i_op(mop), .i_data(mdat), .i_addr(maddr),
    .i_delay(mdly), .o_ack(mack));
  initial begin
    forever #25 clk = ~clk;
  end
  // pulses last one cycle, so the falling edge sees each exactly once
  always @(negedge clk) begin
    if (excv === 1'b1) begin
      n_exc++;
      last_vec = vec;
    end
    if (flush === 1'b1) n_flush++;
    if (plain === 1'b1) n_plain++;
    if (busy === 1'b1) n_busy++;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one control register write, optionally racing a page fault set up by the caller
  task automatic crw(input logic [1:0] s, input logic [31:0] d);
    @(negedge clk);
    crsel = s;
    crd = d;
    crwr = 1'b1;
    @(negedge clk);
    crwr = 1'b0;
    pfe = 1'b0;
    @(negedge clk);
  endtask
  // single-cycle strobe: 0 float op, 1 interrupt without switch, 2 its return, 3 flag write
  task automatic strobe(input int w);
    @(negedge clk);
    fpx = (w == 0);
    insw = (w == 1);
    hret = (w == 2);
    fwr = (w == 3);
    @(negedge clk);
    {fpx, insw, hret, fwr} = 4'h0;
    @(negedge clk);
  endtask
  // transfer request; base and descriptor address follow the selector
  task automatic xfer(input logic [2:0] k, input logic dt, input logic [3:0] t,
                      input logic [31:0] l, input logic [15:0] s, input logic [31:0] f,
                      input logic tr);
    int i;
    @(negedge clk);
    {kind, dtask, typ, lim, sel, nflg, trap} = {k, dt, t, l, s, f, tr};
    base = {s, 16'h0}; // the bench plays the software that built the tables
    daddr = {16'h0, s};
    xreq = 1'b1;
    @(negedge clk);
    xreq = 1'b0;
    repeat (2) @(negedge clk);
    for (i = 0; i < 80 && busy !== 1'b0; i++) @(negedge clk);
    @(negedge clk);
  endtask
  // switch and check op order: four ops save,busy,link,load; two ops save,load
  task automatic sw(input logic [2:0] k, input logic [3:0] t, input logic [31:0] l,
                    input logic [15:0] s, input logic [31:0] f, input int n, input logic tr);
    int n0;
    int i;
    int nbz;
    n0 = mem.n_ops;
    nbz = n_busy;
    xfer(k, 1'b1, t, l, s, f, tr);
    chk("op_count", mem.n_ops - n0, n);
    chk("busy_seen", {31'h0, n_busy != nbz}, {31'h0, n != 0});
    for (i = 0; i < n; i++) begin
      chk("op_code", {30'h0, mem.op_log[n0 + i]}, (n == 4) ? i : i * 3);
    end
  endtask
  task automatic exc_is(input int nb, input logic [7:0] v);
    chk("exc_count", n_exc - nb, 1);
    chk("exc_vector", {24'h0, last_vec}, {24'h0, v});
  endtask
  task automatic t_reset_ctrl();
    int nb;
    nb = n_exc;
    chk("real_addr", {31'h0, real_a}, 1);
    chk("mcw", mcw, 32'h0);
    sw(3'h1, 4'h9, 32'h100, 16'h0008, 32'h0, 0, 1'b0); // real mode takes no switch
    crw(2'h0, 32'h3); // protection enable plus monitor
    chk("mcw", mcw, 32'h3);
    chk("real_addr", {31'h0, real_a}, 0);
    strobe(0); // task-switched still clear, so no fault
    chk("fp_quiet", n_exc - nb, 0);
    nb = n_flush;
    crw(2'h3, 32'habcd_efff);
    chk("pdb", pdb, 32'habcd_e000);
    chk("flush", n_flush - nb, 1);
    nb = n_flush;
    ce = 1'b0; // a frozen block must ignore the write
    crw(2'h3, 32'h1234_5000);
    ce = 1'b1;
    chk("pdb_held", pdb, 32'habcd_e000);
    chk("flush_held", n_flush - nb, 0);
    crw(2'h2, 32'h1111_2222);
    chk("pfla", pfla, 32'h1111_2222);
    pfl = 32'hdead_0042;
    pfe = 1'b1; // fault lands with a software write
    crw(2'h2, 32'h5555_6666);
    chk("pfla", pfla, 32'hdead_0042);
  endtask
  task automatic t_tasks();
    int nb;
    int n0;
    sw(3'h0, 4'h9, 32'h67, 16'h0010, 32'h200, 2, 1'b0); // first far jump
    chk("flags", flg, 32'h200);
    nb = n_exc;
    n0 = mem.n_ops;
    sw(3'h1, 4'h9, 32'h65, 16'h0028, 32'h0002_0002, 4, 1'b1);
    chk("save_data", mem.dat_log[n0], 32'h200);
    chk("busy_type", {28'h0, mem.dat_log[n0 + 1][3:0]}, 32'hb);
    chk("back_link", {16'h0, mem.dat_log[n0 + 2][15:0]}, 32'h10);
    chk("save_addr", mem.adr_log[n0], 32'h0010_0000);
    chk("busy_addr", mem.adr_log[n0 + 1], 32'h0000_0028);
    chk("link_addr", mem.adr_log[n0 + 2], 32'h0028_0000);
    chk("load_addr", mem.adr_log[n0 + 3], 32'h0028_0000);
    chk("sel", {16'h0, o_sel}, 32'h28);
    chk("base", o_base, 32'h0028_0000);
    chk("limit", o_lim, 32'h65);
    chk("flags", flg, 32'h0002_4002);
    chk("ts", {31'h0, mcw[3]}, 1);
    chk("real_addr", {31'h0, real_a}, 1);
    exc_is(nb, 8'h01);
    nb = n_exc;
    strobe(0);
    exc_is(nb, 8'h07);
    fd = 32'h0000_4000;
    strobe(3); // software cannot drop the virtual flag
    chk("flags", flg, 32'h0002_4000);
    strobe(1);
    chk("flags", flg, 32'h0002_0000);
    strobe(2);
    chk("flags", flg, 32'h0002_4000);
    sw(3'h5, 4'hb, 32'h67, 16'h0010, 32'h200, 2, 1'b0); // nested return
    chk("sel", {16'h0, o_sel}, 32'h10);
    chk("real_addr", {31'h0, real_a}, 0);
    nb = n_plain;
    sw(3'h5, 4'hb, 32'h67, 16'h0018, 32'h0, 0, 1'b0);
    chk("plain_ret", n_plain - nb, 1);
  endtask
  task automatic t_bad_kinds();
    int nb;
    int n0;
    int k;
    nb = n_exc;
    sw(3'h1, 4'hb, 32'h100, 16'h0030, 32'h0, 0, 1'b0); // busy target
    exc_is(nb, 8'h0d);
    nb = n_exc;
    sw(3'h1, 4'h9, 32'h64, 16'h0030, 32'h0, 0, 1'b0); // limit at the floor
    exc_is(nb, 8'h0a);
    nb = n_exc;
    sw(3'h1, 4'h1, 32'h2b, 16'h0030, 32'h0, 0, 1'b0);
    exc_is(nb, 8'h0a);
    n0 = mem.n_ops;
    xfer(3'h1, 1'b0, 4'h9, 32'h100, 16'h0038, 32'h0, 1'b0); // plain segment target
    chk("ignored", mem.n_ops - n0, 0);
    for (k = 2; k <= 4; k++) begin
      mdly = 4'(k); // memory stalls longer each time
      n0 = mem.n_ops;
      sw(3'(k), (k == 2) ? 4'h1 : 4'h9, (k == 2) ? 32'h2c : 32'h100, 16'(64 + k * 8),
         32'h0, 4, 1'b0);
      chk("busy_type", {28'h0, mem.dat_log[n0 + 1][3:0]}, (k == 2) ? 3 : 11);
      chk("nested", {31'h0, flg[14]}, 1);
    end
  endtask
  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    t_reset_ctrl();
    t_tasks();
    t_bad_kinds();
    conclude();
  end
  // the scenarios take well under a thousand cycles
  initial begin
    repeat (6000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule // task_switch_control_tb
`default_nettype wire

// *** bench/tsc_mem_model.sv ***
/*
 tsc_mem_model: system memory holding the task segments, answers each request.
 assumes: requests stand until acknowledged; ack is sampled on the rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module tsc_mem_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [1:0] i_op,
  input wire logic [31:0] i_data,
  input wire logic [31:0] i_addr,
  input wire logic [3:0] i_delay,
  output logic o_ack
);
  int n_ops = 0; // operations answered so far
  int wait_cnt = 0; // cycles spent on the current request
  logic [1:0] op_log [64]; // op codes in answer order
  logic [31:0] dat_log [64]; // write data in answer order
  logic [31:0] adr_log [64]; // addresses in answer order
  initial o_ack = 1'b0;
  // falling edge keeps the ack steady at the sampling edge; slow answers
  // come from i_delay so the sequencer is seen waiting
  always @(negedge i_clk) begin
    if (o_ack) begin
      o_ack <= 1'b0; // one-cycle pulse, the next op is counted afresh
      wait_cnt <= 0;
    end else if (i_req && wait_cnt >= int'(i_delay)) begin
      o_ack <= 1'b1;
      op_log[n_ops[5:0]] <= i_op;
      dat_log[n_ops[5:0]] <= i_data;
      adr_log[n_ops[5:0]] <= i_addr;
      n_ops <= n_ops + 1;
    end else if (i_req) begin
      wait_cnt <= wait_cnt + 1; // still stalling
    end
  end
endmodule // tsc_mem_model
`default_nettype wire

// *** core/task_switch_control.sv ***
/*
 task_switch_control: task switch sequencer, flag and control registers.
 assumes: request inputs come from decode logic on I_CLK, memory answers
 each operation with a one-cycle I_MEM_ACK pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module task_switch_control (
  input wire logic I_CLK, // core clock
  input wire logic I_SRST, // synchronous reset
  input wire logic I_CE, // clock enable
  input wire logic I_XFER_REQ, // transfer request pulse
  input wire logic [2:0] I_XFER_KIND, // jump, call, interrupt, return
  input wire logic I_DESC_TASK, // target is task segment or task gate
  input wire logic [15:0] I_NEW_SEL, // incoming task selector
  input wire logic [31:0] I_NEW_DESC_ADDR, // incoming descriptor address
  input wire logic [3:0] I_NEW_TYPE, // incoming descriptor type
  input wire logic [31:0] I_NEW_BASE, // incoming segment base
  input wire logic [31:0] I_NEW_LIMIT, // incoming segment limit
  input wire logic I_NEW_TRAP, // incoming debug-trap bit
  input wire logic [31:0] I_NEW_FLAGS, // incoming flag image
  input wire logic I_MEM_ACK, // memory done pulse
  input wire logic I_CR_WR, // control register write
  input wire logic [1:0] I_CR_SEL, // control register select
  input wire logic [31:0] I_CR_DATA, // control register data
  input wire logic I_FLAG_WR, // flag pop or return flag write
  input wire logic [31:0] I_FLAG_DATA, // flag write data
  input wire logic I_INT_NOSWITCH, // interrupt taken without switch
  input wire logic I_HANDLER_RET, // that handler returned
  input wire logic I_PF_EVENT, // page fault detected
  input wire logic [31:0] I_PF_LINEAR, // faulting linear address
  input wire logic I_FP_EXEC, // float or wait instruction issued
  output logic O_MEM_REQ, // memory operation request
  output logic [1:0] O_MEM_OP, // memory operation code
  output logic [31:0] O_MEM_ADDR, // memory operation address
  output logic [31:0] O_MEM_DATA, // memory operation write data
  output logic [15:0] O_TASK_SEL, // task segment register selector
  output logic [31:0] O_TASK_BASE, // hidden base
  output logic [31:0] O_TASK_LIMIT, // hidden limit
  output logic [31:0] O_FLAGS, // flag register
  output logic [31:0] O_MCW, // machine control word
  output logic [31:0] O_PFLA, // page fault linear address
  output logic [31:0] O_PDB, // page directory base
  output logic O_TLB_FLUSH, // translation cache flush pulse
  output logic O_EXC_VALID, // exception pulse
  output logic [7:0] O_EXC_VECTOR, // exception vector
  output logic O_PLAIN_RETURN, // ordinary return pulse
  output logic O_REAL_ADDR, // real-mode address formation
  output logic O_SWITCH_BUSY // task switch in progress
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  // all block state in one record, so one process computes and one registers
  typedef struct packed {
    tsc_pkg::sw_state_e state; // sequencer state
    logic [15:0] new_sel; // captured incoming selector
    logic [31:0] desc_addr; // captured descriptor address
    logic [31:0] new_base; // captured base
    logic [31:0] new_limit; // captured limit
    logic new_trap; // captured debug-trap bit
    logic [31:0] new_flags; // captured flag image
    logic nest; // switch nests under the old task
    logic legacy; // incoming segment is 16-bit format
    logic nt_shadow; // nested flag saved across a handler
    logic [15:0] task_sel; // current selector
    logic [31:0] task_base; // current base
    logic [31:0] task_limit; // current limit
    logic [31:0] flags; // flag register
    logic [31:0] mcw; // machine control word
    logic [31:0] pfla; // fault address
    logic [31:0] pdb; // directory base
    logic mem_req; // memory request
    logic [1:0] mem_op; // memory op
    logic [31:0] mem_addr; // memory address
    logic [31:0] mem_data; // memory data
    logic tlb_flush; // flush pulse
    logic exc_valid; // exception pulse
    logic [7:0] exc_vec; // exception vector
    logic plain_ret; // ordinary return pulse
    logic real_addr; // real addressing
    logic switch_busy; // switch in progress
  } ctx_s;
  ctx_s c; // registered state
  ctx_s next_c; // next state
  logic is_tss; // type is any task segment
  logic is_legacy; // type is 16-bit format
  logic is_busy; // type is marked busy
  logic limit_ok; // limit exceeds the format minimum
  logic nesting; // kind links back to the old task
  logic start; // a task switch begins now
  // decode the incoming descriptor; return needs the nested flag set
  always_comb begin
    is_legacy = (I_NEW_TYPE == tsc_pkg::LEGACY_FREE) || (I_NEW_TYPE == tsc_pkg::LEGACY_BUSY);
    is_busy = (I_NEW_TYPE == tsc_pkg::NATIVE_BUSY) || (I_NEW_TYPE == tsc_pkg::LEGACY_BUSY);
    is_tss = is_legacy || (I_NEW_TYPE == tsc_pkg::NATIVE_FREE) || is_busy;
    limit_ok = is_legacy ? (I_NEW_LIMIT > tsc_pkg::LEGACY_MIN_LIMIT)
                         : (I_NEW_LIMIT > tsc_pkg::NATIVE_MIN_LIMIT);
    nesting = (I_XFER_KIND == tsc_pkg::XF_CALL) || (I_XFER_KIND == tsc_pkg::XF_SOFT_INT) ||
              (I_XFER_KIND == tsc_pkg::XF_EXCEPT) || (I_XFER_KIND == tsc_pkg::XF_EXT_INT);
    // jumps, calls and gated interrupts switch only in protected mode
    start = (c.state == tsc_pkg::ST_IDLE) && I_XFER_REQ && c.mcw[tsc_pkg::PE_BIT] &&
            ((I_XFER_KIND == tsc_pkg::XF_INTERRUPT_RETURN) ? c.flags[tsc_pkg::NT_BIT]
                                               : I_DESC_TASK);
  end
  // next values of every register
  always_comb begin
    next_c = c;
    next_c.tlb_flush = 1'b0; // pulses last one cycle
    next_c.exc_valid = 1'b0;
    next_c.plain_ret = 1'b0;
    // move-to-control-register writes
    if (I_CR_WR) begin
      case (I_CR_SEL)
        tsc_pkg::CR_MCW: next_c.mcw = I_CR_DATA;
        tsc_pkg::CR_PFLA: next_c.pfla = I_CR_DATA;
        tsc_pkg::CR_PDB: begin
          // directory sits on a 4 Kbyte page, low bits forced zero
          next_c.pdb = I_CR_DATA & tsc_pkg::PDB_ALIGN_MASK;
          next_c.tlb_flush = 1'b1;
        end
        default: ; // other selects are not held here
      endcase
    end
    // a fault in the same cycle as a software write wins
    if (I_PF_EVENT) begin
      next_c.pfla = I_PF_LINEAR;
    end
    // flag pop keeps the virtual legacy flag, only a switch may change it
    if (I_FLAG_WR) begin
      next_c.flags = (I_FLAG_DATA & ~tsc_pkg::VM_MASK) | (c.flags & tsc_pkg::VM_MASK);
    end
    // limitation: one level of handler nesting is remembered
    if (I_INT_NOSWITCH) begin
      next_c.nt_shadow = c.flags[tsc_pkg::NT_BIT];
      next_c.flags[tsc_pkg::NT_BIT] = 1'b0;
    end else if (I_HANDLER_RET) begin
      next_c.flags[tsc_pkg::NT_BIT] = c.nt_shadow;
    end
    // float unit not available after a switch when the monitor bit is set, handler decides on saving
    if (I_FP_EXEC && c.mcw[tsc_pkg::TS_BIT] && c.mcw[tsc_pkg::MP_BIT]) begin
      next_c.exc_valid = 1'b1;
      next_c.exc_vec = tsc_pkg::EXC_NO_FPU;
    end
    // task switch sequencer; its exceptions override the float one
    case (c.state)
      tsc_pkg::ST_IDLE: begin
        if (start) begin
          next_c.new_sel = I_NEW_SEL;
          next_c.desc_addr = I_NEW_DESC_ADDR;
          next_c.new_base = I_NEW_BASE;
          next_c.new_limit = I_NEW_LIMIT;
          next_c.new_trap = I_NEW_TRAP;
          next_c.new_flags = I_NEW_FLAGS;
          next_c.legacy = is_legacy;
          next_c.nest = nesting;
          if (!is_tss || (is_busy && (I_XFER_KIND != tsc_pkg::XF_INTERRUPT_RETURN))) begin
            next_c.exc_valid = 1'b1;
            next_c.exc_vec = tsc_pkg::EXC_PROTECT;
          end else if (!limit_ok) begin
            next_c.exc_valid = 1'b1;
            next_c.exc_vec = tsc_pkg::EXC_BAD_TSS;
          end else begin
            // first store the outgoing task into its own segment
            next_c.state = tsc_pkg::ST_SAVE;
            next_c.switch_busy = 1'b1;
            next_c.mem_req = 1'b1;
            next_c.mem_op = tsc_pkg::MOP_SAVE;
            next_c.mem_addr = c.task_base;
            next_c.mem_data = c.flags;
          end
        end else if (I_XFER_REQ && c.mcw[tsc_pkg::PE_BIT] &&
                     (I_XFER_KIND == tsc_pkg::XF_INTERRUPT_RETURN)) begin
          next_c.plain_ret = 1'b1;
        end
      end
      tsc_pkg::ST_SAVE: begin
        if (I_MEM_ACK) begin
          if (c.nest) begin
            // rewrite the incoming descriptor type as busy
            next_c.state = tsc_pkg::ST_BUSY;
            next_c.mem_op = tsc_pkg::MOP_BUSY;
            next_c.mem_addr = c.desc_addr;
            next_c.mem_data = {28'h0000000, c.legacy ? tsc_pkg::LEGACY_BUSY
                                                     : tsc_pkg::NATIVE_BUSY};
          end else begin
            next_c.state = tsc_pkg::ST_LOAD;
            next_c.mem_op = tsc_pkg::MOP_LOAD;
            next_c.mem_addr = c.new_base;
            next_c.mem_data = 32'h00000000;
          end
        end
      end
      tsc_pkg::ST_BUSY: begin
        if (I_MEM_ACK) begin
          // back link of the new segment names the outgoing task
          next_c.state = tsc_pkg::ST_LINK;
          next_c.mem_op = tsc_pkg::MOP_LINK;
          next_c.mem_addr = c.new_base + tsc_pkg::BACKLINK_OFFSET;
          next_c.mem_data = {16'h0000, c.task_sel};
        end
      end
      tsc_pkg::ST_LINK: begin
        if (I_MEM_ACK) begin
          next_c.state = tsc_pkg::ST_LOAD;
          next_c.mem_op = tsc_pkg::MOP_LOAD;
          next_c.mem_addr = c.new_base;
          next_c.mem_data = 32'h00000000;
        end
      end
      tsc_pkg::ST_LOAD: begin
        if (I_MEM_ACK) begin
          next_c.state = tsc_pkg::ST_IDLE;
          next_c.mem_req = 1'b0;
          next_c.switch_busy = 1'b0;
          // selector and its hidden part change together
          next_c.task_sel = c.new_sel;
          next_c.task_base = c.new_base;
          next_c.task_limit = c.new_limit;
          // whole new flag image; only here may the virtual legacy flag change
          next_c.flags = c.new_flags;
          if (c.nest) begin
            next_c.flags[tsc_pkg::NT_BIT] = 1'b1;
          end
          next_c.mcw[tsc_pkg::TS_BIT] = 1'b1;
          if (c.new_trap) begin
            next_c.exc_valid = 1'b1;
            next_c.exc_vec = tsc_pkg::EXC_DEBUG;
          end
        end
      end
      default: next_c.state = tsc_pkg::ST_IDLE;
    endcase
    // address formation follows the final control and flag values
    next_c.real_addr = !next_c.mcw[tsc_pkg::PE_BIT] || next_c.flags[tsc_pkg::VM_BIT];
  end
  // register everything; reset leaves the core in real mode
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      c <= '0;
      c.state <= tsc_pkg::ST_IDLE;
      c.mcw <= tsc_pkg::MCW_RESET;
      c.flags <= tsc_pkg::FLAGS_RESET;
      c.pdb <= tsc_pkg::PDB_RESET;
      c.real_addr <= 1'b1;
    end else if (I_CE) begin
      c <= next_c;
    end
  end
  // outputs straight from the state record
  assign O_MEM_REQ = c.mem_req;
  assign O_MEM_OP = c.mem_op;
  assign O_MEM_ADDR = c.mem_addr;
  assign O_MEM_DATA = c.mem_data;
  assign O_TASK_SEL = c.task_sel;
  assign O_TASK_BASE = c.task_base;
  assign O_TASK_LIMIT = c.task_limit;
  assign O_FLAGS = c.flags;
  assign O_MCW = c.mcw;
  assign O_PFLA = c.pfla;
  assign O_PDB = c.pdb;
  assign O_TLB_FLUSH = c.tlb_flush;
  assign O_EXC_VALID = c.exc_valid;
  assign O_EXC_VECTOR = c.exc_vec;
  assign O_PLAIN_RETURN = c.plain_ret;
  assign O_REAL_ADDR = c.real_addr;
  assign O_SWITCH_BUSY = c.switch_busy;

  // steps of a switch
  sequence s_start; I_CE && start; endsequence
  sequence s_load_done; I_CE && (c.state == tsc_pkg::ST_LOAD) && I_MEM_ACK; endsequence
  sequence s_save_nest; I_CE && (c.state == tsc_pkg::ST_SAVE) && I_MEM_ACK && c.nest; endsequence
  property p_busy_fault;
    s_start ##0 (I_XFER_KIND != tsc_pkg::XF_INTERRUPT_RETURN) && is_busy
      |=> O_EXC_VALID && (O_EXC_VECTOR == tsc_pkg::EXC_PROTECT) && !O_MEM_REQ;
  endproperty
  a_busy_fault: assert property (p_busy_fault) else $error("busy segment not faulted");
  property p_save_first;
    s_start ##0 is_tss && limit_ok && !is_busy
      |=> O_MEM_REQ && (O_MEM_OP == tsc_pkg::MOP_SAVE) && O_SWITCH_BUSY;
  endproperty
  a_save_first: assert property (p_save_first) else $error("switch did not save first");
  property p_busy_code;
    s_save_nest |=> (O_MEM_OP == tsc_pkg::MOP_BUSY) &&
      (O_MEM_DATA[3:0] == ($past(c.legacy) ? tsc_pkg::LEGACY_BUSY : tsc_pkg::NATIVE_BUSY));
  endproperty
  a_busy_code: assert property (p_busy_code) else $error("wrong busy type code");
  property p_load_task;
    s_load_done |=> (O_TASK_SEL == $past(c.new_sel)) && (O_TASK_BASE == $past(c.new_base))
      && O_MCW[tsc_pkg::TS_BIT] && !O_SWITCH_BUSY;
  endproperty
  a_load_task: assert property (p_load_task) else $error("task load incomplete");
  property p_nest_set;
    s_load_done ##0 c.nest |=> O_FLAGS[tsc_pkg::NT_BIT];
  endproperty
  a_nest_set: assert property (p_nest_set) else $error("nested flag not set");
  property p_fpu_fault;
    I_CE && I_FP_EXEC && O_MCW[tsc_pkg::TS_BIT] && O_MCW[tsc_pkg::MP_BIT] &&
      !start && !(c.state == tsc_pkg::ST_LOAD)
      |=> O_EXC_VALID && (O_EXC_VECTOR == tsc_pkg::EXC_NO_FPU);
  endproperty
  a_fpu_fault: assert property (p_fpu_fault) else $error("float fault missing");
  property p_vm_kept;
    I_CE && (c.state != tsc_pkg::ST_LOAD) |=> $stable(O_FLAGS[tsc_pkg::VM_BIT]);
  endproperty
  a_vm_kept: assert property (p_vm_kept) else $error("legacy flag changed");
  property p_flush;
    I_CE && I_CR_WR && (I_CR_SEL == tsc_pkg::CR_PDB)
      |=> O_TLB_FLUSH && (O_PDB[11:0] == 12'h000);
  endproperty
  a_flush: assert property (p_flush) else $error("base write did not flush");
  property p_fault_addr;
    I_CE && I_PF_EVENT |=> (O_PFLA == $past(I_PF_LINEAR));
  endproperty
  a_fault_addr: assert property (p_fault_addr) else $error("fault address missed");
endmodule // task_switch_control
`default_nettype wire

// *** core/tsc_pkg.sv ***
/*
 tsc_pkg: constants and types for the task switch control block.
 assumes: one consumer module, all values referenced with the package scope.
*/
`default_nettype none
package tsc_pkg;
  // flag register and machine control word bit positions
  localparam int NT_BIT = 14;
  localparam int VM_BIT = 17;
  localparam int TS_BIT = 3;
  localparam int MP_BIT = 1;
  localparam int PE_BIT = 0;
  localparam logic [31:0] VM_MASK = 32'h1 << VM_BIT;
  // least task segment limits, the limit must exceed these
  localparam logic [31:0] NATIVE_MIN_LIMIT = 32'h0000_0064;
  localparam logic [31:0] LEGACY_MIN_LIMIT = 32'h0000_002b;
  // descriptor type codes of task segments
  localparam logic [3:0] NATIVE_FREE = 4'h9;
  localparam logic [3:0] NATIVE_BUSY = 4'hb;
  localparam logic [3:0] LEGACY_FREE = 4'h1;
  localparam logic [3:0] LEGACY_BUSY = 4'h3;
  // exception vectors
  localparam logic [7:0] EXC_DEBUG = 8'h01;
  localparam logic [7:0] EXC_NO_FPU = 8'h07;
  localparam logic [7:0] EXC_BAD_TSS = 8'h0a;
  localparam logic [7:0] EXC_PROTECT = 8'h0d;
  // control register selects for move-to-control-register
  localparam logic [1:0] CR_MCW = 2'h0;
  localparam logic [1:0] CR_PFLA = 2'h2;
  localparam logic [1:0] CR_PDB = 2'h3;
  // transfer kinds
  localparam logic [2:0] XF_JMP = 3'h0;
  localparam logic [2:0] XF_CALL = 3'h1;
  localparam logic [2:0] XF_SOFT_INT = 3'h2;
  localparam logic [2:0] XF_EXCEPT = 3'h3;
  localparam logic [2:0] XF_EXT_INT = 3'h4;
  localparam logic [2:0] XF_INTERRUPT_RETURN = 3'h5;
  // memory operations toward the task segments
  localparam logic [1:0] MOP_SAVE = 2'h0;
  localparam logic [1:0] MOP_BUSY = 2'h1;
  localparam logic [1:0] MOP_LINK = 2'h2;
  localparam logic [1:0] MOP_LOAD = 2'h3;
  // paging: directory and tables are 4 Kbyte pages
  localparam logic [31:0] PDB_ALIGN_MASK = 32'hffff_f000;
  localparam logic [31:0] BACKLINK_OFFSET = 32'h0000_0000;
  // reset values
  localparam logic [31:0] MCW_RESET = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [31:0] PDB_RESET = 32'h0000_0000;
  // task switch sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_SAVE, ST_BUSY, ST_LINK, ST_LOAD} sw_state_e;
endpackage
`default_nettype wire
